// ### include/instr_decode_pkg.sv
// shared constants, enums and field structs for the instruction field decoder
package instr_decode_pkg;

  // ----------------------------------------
  // widths and positions
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int FILE_W = 8;
  localparam int PERIPH_W = 5;
  localparam int BIT_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT13_W = 13;
  localparam int DEST_POS = 8;
  localparam int STORE_POS = 8;
  localparam int TBYTE_POS = 9;
  localparam int TINC_POS = 8;
  localparam int BITNUM_POS = 8;
  localparam int PERIPH_POS = 8;
  localparam int IRQ_DIS_POS = 4;
  localparam int TWRITE_POS = 10;
  localparam logic [7:0] PC_LOW_ADDR = 8'h02;
  localparam int Q_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_RESET = 2'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // ----------------------------------------
  // instruction classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    CLS_NOP, CLS_BYTE_D, CLS_BYTE_S, CLS_BYTE_SKIP, CLS_BYTE_ONLY, CLS_MOVE_P,
    CLS_BIT, CLS_BIT_SKIP, CLS_TBL_LATCH, CLS_TBL_RW, CLS_LIT8, CLS_LIT8_BRANCH,
    CLS_LIT13, CLS_RESERVED
  } instr_class_t;

  // decoded operand fields handed to the execution pipeline
  typedef struct packed {
    instr_class_t cls;
    logic [7:0] file_addr;
    logic [4:0] periph_addr;
    logic [2:0] bit_num;
    logic [7:0] lit8;
    logic [12:0] lit13;
    logic dest_to_file;
    logic write_accumulator;
    logic write_file;
    logic table_high_byte;
    logic table_ptr_inc;
    logic two_cycle;
    logic rmw_bit;
    logic pc_low_write;
  } decoded_t;

  // table latch as two addressable bytes
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } table_latch_t;

endpackage

// ### design/instruction_field_decoder.sv
// instruction field decoder with cycle sequencer, table pointer and latch, pc high copy
// Behaviour
// - each instruction is one 16-bit word
// - d zero to accumulator, one to file
// - s zero writes both, one file only
// - file address is 8-bit, 00h to FFh
// - peripheral address is 5-bit, 00h to 1Fh
// - i one increments table pointer after
// - t selects table latch low or high
// - bit number picks bit in file byte
// - literal is 8 or 13 bits
// - one cycle; two for skip, branch, table
// - instruction cycle is four oscillator periods
// - don't-care opcode bits never change decoding
// - unassigned opcodes are reserved, undefined behaviour
// - global interrupt disable is status bit 4
// - 16-bit table pointer and 16-bit latch
// - bit ops read, modify bit, write byte
// - pc low write copies holding latch high
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module instruction_field_decoder (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic cond_true,
  input wire logic [7:0] cpu_status_register,
  input wire logic tbl_ptr_load,
  input wire logic [15:0] tbl_ptr_value,
  input wire logic latch_write,
  input wire logic [7:0] latch_byte,
  input wire logic [15:0] table_read_data,
  input wire logic pc_low_write,
  input wire logic [7:0] pc_low_value,
  input wire logic holding_write,
  input wire logic [7:0] holding_value,
  output instr_decode_pkg::decoded_t fields,
  output logic [1:0] q_phase,
  output logic fetch_strobe,
  output logic second_cycle_nop,
  output logic global_irq_disable,
  output logic [15:0] table_pointer,
  output instr_decode_pkg::table_latch_t table_latch,
  output logic [7:0] table_byte_out,
  output logic [7:0] pc_low_byte,
  output logic [7:0] pc_high_byte,
  output logic [7:0] pc_high_holding_latch
);
  import instr_decode_pkg::*;

  // ----------------------------------------
  // combinational field extraction
  // ----------------------------------------
  decoded_t dec_next;
  logic [3:0] top;
  logic [3:0] mid;

  // opcode nibbles; don't-care positions are never inspected
  assign top = instr_word[15:12];
  assign mid = instr_word[11:8];

  // class and operand split of the 16-bit word
  always_comb begin
    dec_next = '0;
    dec_next.file_addr = instr_word[FILE_W-1:0];
    dec_next.table_high_byte = instr_word[TBYTE_POS];
    dec_next.cls = CLS_RESERVED;
    case (top)
      4'h0: begin
        if (instr_word == WORD_RESET) begin
          dec_next.cls = CLS_NOP;
        end else if (mid == 4'h1) begin
          dec_next.cls = CLS_BYTE_ONLY;
        end else if (mid[3:1] != 3'h0) begin
          dec_next.cls = CLS_BYTE_D;
        end else begin
          dec_next.cls = CLS_BYTE_D;
        end
      end
      4'h1: begin
        dec_next.cls = (mid[3:1] == 3'h3 || mid[3:1] == 3'h7) ? CLS_BYTE_SKIP : CLS_BYTE_D;
      end
      4'h2: begin
        if (mid[3:1] == 3'h2 || mid[3:1] == 3'h3) begin
          dec_next.cls = CLS_BYTE_SKIP;
        end else if (mid[3]) begin
          dec_next.cls = CLS_BYTE_S;
        end else begin
          dec_next.cls = CLS_BYTE_D;
        end
      end
      4'h3: begin
        if (mid <= 4'h2) begin
          dec_next.cls = CLS_BYTE_SKIP;
        end else if (mid == 4'h4) begin
          dec_next.cls = CLS_BYTE_ONLY;
        end
      end
      4'h4, 4'h5, 4'h6, 4'h7: dec_next.cls = CLS_MOVE_P;
      4'h8: dec_next.cls = CLS_BIT;
      4'h9: dec_next.cls = CLS_BIT_SKIP;
      4'hA: dec_next.cls = mid[3] ? CLS_TBL_RW : CLS_TBL_LATCH;
      4'hB: dec_next.cls = CLS_LIT8;
      4'hC, 4'hD, 4'hE, 4'hF: dec_next.cls = CLS_LIT13;
      default: dec_next.cls = CLS_RESERVED;
    endcase
    // destination handling per format
    case (dec_next.cls)
      CLS_BYTE_D: begin
        dec_next.dest_to_file = instr_word[DEST_POS];
        dec_next.write_file = instr_word[DEST_POS];
        dec_next.write_accumulator = ~instr_word[DEST_POS];
      end
      CLS_BYTE_S: begin
        dec_next.dest_to_file = 1'b1;
        dec_next.write_file = 1'b1;
        dec_next.write_accumulator = ~instr_word[STORE_POS];
      end
      CLS_BYTE_ONLY: begin
        dec_next.dest_to_file = 1'b1;
        dec_next.write_file = 1'b1;
      end
      // peripheral, bit and literal fields are taken only by the formats that own them; file address and t bit come from every word
      CLS_MOVE_P: begin
        dec_next.periph_addr = instr_word[PERIPH_POS+PERIPH_W-1:PERIPH_POS];
        dec_next.dest_to_file = 1'b1;
        dec_next.write_file = 1'b1;
      end
      CLS_BIT: begin
        dec_next.bit_num = instr_word[BITNUM_POS+BIT_W-1:BITNUM_POS];
        dec_next.rmw_bit = 1'b1;
        dec_next.write_file = 1'b1;
        dec_next.dest_to_file = 1'b1;
      end
      CLS_BIT_SKIP: begin
        dec_next.bit_num = instr_word[BITNUM_POS+BIT_W-1:BITNUM_POS];
      end
      CLS_TBL_RW: begin
        dec_next.table_ptr_inc = instr_word[TINC_POS];
        dec_next.two_cycle = 1'b1;
      end
      CLS_LIT8: begin
        dec_next.lit8 = instr_word[LIT8_W-1:0];
      end
      CLS_LIT13: begin
        dec_next.lit13 = instr_word[LIT13_W-1:0];
        dec_next.two_cycle = 1'b1;
      end
      // latch-only table ops keep their don't-care bit out of every field
      default: begin
        dec_next.dest_to_file = 1'b0;
      end
    endcase
    // skips on a true test and writes of pc low need the extra cycle
    if ((dec_next.cls == CLS_BYTE_SKIP || dec_next.cls == CLS_BIT_SKIP) && cond_true) begin
      dec_next.two_cycle = 1'b1;
    end
    dec_next.pc_low_write = dec_next.write_file && (dec_next.file_addr == PC_LOW_ADDR);
    if (dec_next.pc_low_write) begin
      dec_next.two_cycle = 1'b1;
    end
  end

  // ----------------------------------------
  // q-phase sequencer
  // ----------------------------------------
  logic [1:0] q_reg;
  logic nop_pending_reg;

  // four oscillator periods per instruction cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      q_reg <= Q_RESET;
    end else begin
      q_reg <= q_reg + 2'h1;
    end
  end
  assign q_phase = q_reg;

  // fetch strobe marks the end of each instruction cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_strobe <= 1'b0;
    end else begin
      fetch_strobe <= (q_reg == Q_LAST - 2'h1);
    end
  end

  // latch fields in the decode phase; a pending forced nop blanks the cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      fields <= '0;
      nop_pending_reg <= 1'b0;
      second_cycle_nop <= 1'b0;
    end else if (q_reg == Q_RESET) begin
      if (nop_pending_reg) begin
        fields <= '0;
        nop_pending_reg <= 1'b0;
        second_cycle_nop <= 1'b1;
      end else begin
        fields <= dec_next;
        nop_pending_reg <= dec_next.two_cycle;
        second_cycle_nop <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // status, table pointer and latch
  // ----------------------------------------
  // interrupt disable mirror from the cpu status byte
  always_ff @(posedge clock) begin
    if (rst) begin
      global_irq_disable <= 1'b0;
    end else begin
      global_irq_disable <= cpu_status_register[IRQ_DIS_POS];
    end
  end

  // remember increment, byte and read requests across the forced nop cycle
  logic inc_armed_reg;
  logic high_sel_reg;
  logic read_armed_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      inc_armed_reg <= 1'b0;
      high_sel_reg <= 1'b0;
      read_armed_reg <= 1'b0;
    end else if (q_reg == Q_RESET && !nop_pending_reg) begin
      inc_armed_reg <= dec_next.table_ptr_inc;
      high_sel_reg <= dec_next.table_high_byte;
      read_armed_reg <= (dec_next.cls == CLS_TBL_RW) && !instr_word[TWRITE_POS]; // table writes keep the latch
    end
  end

  // pointer load or post-increment at the end of a table transfer
  always_ff @(posedge clock) begin
    if (rst) begin
      table_pointer <= WORD_RESET;
    end else if (tbl_ptr_load) begin
      table_pointer <= tbl_ptr_value;
    end else if (second_cycle_nop && fields.cls == CLS_NOP && q_reg == Q_LAST && inc_armed_reg) begin
      table_pointer <= table_pointer + PTR_STEP;
    end
  end

  // byte-wise latch writes, whole-word load on table read
  always_ff @(posedge clock) begin
    if (rst) begin
      table_latch <= '0;
    end else if (latch_write) begin
      if (high_sel_reg) begin
        table_latch.high <= latch_byte;
      end else begin
        table_latch.low <= latch_byte;
      end
    end else if (second_cycle_nop && q_reg == Q_LAST && read_armed_reg) begin
      table_latch <= table_read_data;
    end
  end

  // selected latch byte for latch-read operations
  always_ff @(posedge clock) begin
    if (rst) begin
      table_byte_out <= BYTE_RESET;
    end else begin
      table_byte_out <= high_sel_reg ? table_latch.high : table_latch.low;
    end
  end

  // ----------------------------------------
  // program counter bytes
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pc_low_byte <= BYTE_RESET;
      pc_high_byte <= BYTE_RESET;
      pc_high_holding_latch <= BYTE_RESET;
    end else begin
      if (holding_write) begin
        pc_high_holding_latch <= holding_value;
      end
      if (pc_low_write) begin
        pc_low_byte <= pc_low_value;
        pc_high_byte <= pc_high_holding_latch;
      end
    end
  end

endmodule

// ### tb/instruction_field_decoder_properties.sv
// timing checker for the instruction field decoder ports
module instruction_field_decoder_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] cpu_status_register,
  input wire logic tbl_ptr_load,
  input wire logic [15:0] tbl_ptr_value,
  input wire logic pc_low_write,
  input wire logic [7:0] pc_low_value,
  input wire logic holding_write,
  input wire logic [7:0] holding_value,
  input wire instr_decode_pkg::decoded_t fields,
  input wire logic [1:0] q_phase,
  input wire logic fetch_strobe,
  input wire logic second_cycle_nop,
  input wire logic global_irq_disable,
  input wire logic [15:0] table_pointer,
  input wire logic [7:0] pc_low_byte,
  input wire logic [7:0] pc_high_byte,
  input wire logic [7:0] pc_high_holding_latch
);
  import instr_decode_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // the forced nop fills all four phases of the following cycle
  sequence nop_cycle;
    second_cycle_nop [*4];
  endsequence
  chk_q_wrap: assert property (q_phase == Q_LAST |=> q_phase == Q_RESET) else $error("q phase did not wrap");
  chk_q_step: assert property (q_phase != Q_LAST |=> q_phase == $past(q_phase) + 2'h1) else $error("q phase skipped");
  chk_fetch_phase: assert property (fetch_strobe == (q_phase == Q_LAST)) else $error("fetch strobe off phase");
  chk_fields_stand: assert property (q_phase != 2'h1 |-> $stable(fields)) else $error("fields moved mid cycle");
  chk_dest_field: assert property (q_phase == 2'h1 && fields.cls == CLS_BYTE_D |->
    fields.dest_to_file == $past(instr_word[DEST_POS]) && fields.file_addr == $past(instr_word[7:0]))
    else $error("byte fields wrong");
  chk_two_cycle: assert property (q_phase == 2'h1 && fields.two_cycle |-> ##4 nop_cycle) else $error("no forced nop");
  chk_irq_mirror: assert property (!rst |=> global_irq_disable == $past(cpu_status_register[IRQ_DIS_POS]))
    else $error("irq disable not mirrored");
  chk_ptr_load: assert property (tbl_ptr_load |=> table_pointer == $past(tbl_ptr_value)) else $error("pointer load lost");
  chk_holding_wr: assert property (holding_write |=> pc_high_holding_latch == $past(holding_value))
    else $error("holding latch not written");
  chk_pc_copy: assert property (pc_low_write |=> pc_high_byte == $past(pc_high_holding_latch)
    && pc_low_byte == $past(pc_low_value)) else $error("pc high copy missing");
endmodule

bind instruction_field_decoder instruction_field_decoder_properties chk (.clock, .rst, .instr_word,
  .cpu_status_register, .tbl_ptr_load, .tbl_ptr_value, .pc_low_write, .pc_low_value, .holding_write,
  .holding_value, .fields, .q_phase, .fetch_strobe, .second_cycle_nop, .global_irq_disable, .table_pointer,
  .pc_low_byte, .pc_high_byte, .pc_high_holding_latch);

// ### tb/instruction_field_decoder_test.sv
// self-checking bench for the instruction field decoder
module instruction_field_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  import instr_decode_pkg::*;
  logic clock = 0, rst = 1, cond_true = 0, tbl_ptr_load = 0, latch_write = 0, pc_low_write = 0, holding_write = 0;
  logic [15:0] instr_word = 16'h0000, tbl_ptr_value = 16'h0000, table_read_data = 16'hC3E1, table_pointer;
  logic [7:0] cpu_status_register = 8'h00, latch_byte = 8'h00, pc_low_value = 8'h00, holding_value = 8'h00;
  logic [7:0] table_byte_out, pc_low_byte, pc_high_byte, pc_high_holding_latch;
  logic [1:0] q_phase;
  logic fetch_strobe, second_cycle_nop, global_irq_disable;
  decoded_t fields, held;
  table_latch_t table_latch;
  int n_errors = 0, n_checks = 0, cycles = 0;
  always #50 clock = ~clock;
  instruction_field_decoder DUT (.clock(clock), .rst(rst), .instr_word(instr_word), .cond_true(cond_true),
    .cpu_status_register(cpu_status_register), .tbl_ptr_load(tbl_ptr_load), .tbl_ptr_value(tbl_ptr_value),
    .latch_write(latch_write), .latch_byte(latch_byte), .table_read_data(table_read_data),
    .pc_low_write(pc_low_write), .pc_low_value(pc_low_value), .holding_write(holding_write),
    .holding_value(holding_value), .fields(fields), .q_phase(q_phase), .fetch_strobe(fetch_strobe),
    .second_cycle_nop(second_cycle_nop), .global_irq_disable(global_irq_disable), .table_pointer(table_pointer),
    .table_latch(table_latch), .table_byte_out(table_byte_out), .pc_low_byte(pc_low_byte),
    .pc_high_byte(pc_high_byte), .pc_high_holding_latch(pc_high_holding_latch));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  // offer a word through the q zero phase, fall back to nop, return once its fields settle
  task automatic run(input logic [15:0] w);
    do @(negedge clock); while (q_phase !== 2'h3);
    @(posedge clock) instr_word <= w;
    @(posedge clock) instr_word <= 16'h0000;
    @(negedge clock);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    run(16'h0EA5);
    check({fields.dest_to_file, fields.two_cycle, fields.file_addr}, 10'h0A5);
    run(16'h0F00);
    check({fields.dest_to_file, fields.file_addr}, 9'h100);
    run(16'h0EFF);
    check(fields.file_addr, 8'hFF);
    run(16'h2800);
    check({fields.write_file, fields.write_accumulator}, 2'h3);
    run(16'h2900);
    check({fields.write_file, fields.write_accumulator}, 2'h2);
    run(16'h5F3C);
    check({fields.periph_addr, fields.file_addr}, 13'h1F3C);
    run(16'h403C);
    check(fields.periph_addr, 5'h00);
    run(16'hA234);
    held = fields;
    run(16'hA334);
    check(fields, held);
    check({fields.table_high_byte, fields.two_cycle}, 2'h2);
    @(posedge clock) {latch_write, latch_byte} <= 9'h15A;
    @(posedge clock) latch_write <= 0;
    run(16'hA034);
    @(posedge clock) {latch_write, latch_byte} <= 9'h196;
    @(posedge clock) latch_write <= 0;
    @(negedge clock) check(table_latch, 16'h5A96);
    @(negedge clock) check(table_byte_out, 8'h96);
    @(posedge clock) {tbl_ptr_load, tbl_ptr_value} <= 17'h1FFFF;
    @(posedge clock) tbl_ptr_load <= 0;
    run(16'hAB12);
    check({fields.two_cycle, fields.table_high_byte, fields.table_ptr_inc}, 3'h7);
    repeat (4) @(negedge clock);
    check(second_cycle_nop, 1'b1);
    repeat (4) @(negedge clock);
    check({table_pointer, table_latch}, 32'h0000C3E1);
    run(16'hA812);
    check({fields.two_cycle, fields.table_ptr_inc}, 2'h2);
    repeat (8) @(negedge clock);
    check(table_pointer, 16'h0000);
    run(16'h8D40);
    check({fields.bit_num, fields.rmw_bit, fields.write_file, fields.file_addr}, 13'h1740);
    check({fields.rmw_bit, fields.write_file, fields.two_cycle}, 3'h6);
    run(16'hB07F);
    check({fields.two_cycle, fields.lit8}, 9'h07F);
    run(16'hD5A5);
    check({fields.two_cycle, fields.lit13}, 14'h35A5);
    repeat (4) @(negedge clock);
    run(16'h3800);
    check({fields.cls, fields.write_file, fields.write_accumulator, fields.two_cycle}, {CLS_RESERVED, 3'h0});
    run(16'h1600);
    check({fields.cls, fields.two_cycle}, {CLS_BYTE_SKIP, 1'b0});
    @(posedge clock) cond_true <= 1'b1;
    run(16'h1600);
    check({fields.cls, fields.two_cycle}, {CLS_BYTE_SKIP, 1'b1});
    @(posedge clock) cond_true <= 1'b0;
    repeat (4) @(negedge clock);
    run(16'h0F02);
    check({fields.pc_low_write, fields.two_cycle}, 2'h3);
    repeat (4) @(negedge clock);
    check(table_latch, 16'hC3E1);
    @(posedge clock) cpu_status_register <= 8'h10;
    repeat (2) @(negedge clock);
    check(global_irq_disable, 1'b1);
    @(posedge clock) cpu_status_register <= 8'hEF;
    repeat (2) @(negedge clock);
    check(global_irq_disable, 1'b0);
    @(posedge clock) {holding_write, holding_value} <= 9'h13C;
    @(posedge clock) {holding_write, pc_low_write, pc_low_value} <= 10'h17E;
    @(posedge clock) pc_low_write <= 0;
    @(negedge clock) check({pc_high_byte, pc_low_byte}, 16'h3C7E);
    conclude();
  end
endmodule
